// ---- design/cbo_defines.svh ----
// Purpose: Offsets, writable masks, reset values for the output config bank
// Assumes: Byte-wide register port, synchronous to i_ref_clk
// Notes: Included by the bank module
`ifndef CBO_DEFINES_SVH
`define CBO_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define CBO_OFF_STOP 8'h0b
`define CBO_OFF_IMP_LO 8'h0c
`define CBO_OFF_IMP_HI 8'h0d
`define CBO_OFF_PULL_LO 8'h0e
`define CBO_OFF_PULL_HI 8'h0f
`define CBO_OFF_PWR_PULL 8'h10
`define CBO_OFF_EN_POL 8'h12
`define CBO_OFF_PWR_POL 8'h13

// ****************************************
// Writable masks
// ****************************************
`define CBO_MASK_STOP 8'h03
`define CBO_MASK_TRIPLE 8'hf3
`define CBO_MASK_PWR_PULL 8'h03
`define CBO_MASK_EN_POL 8'hdd
`define CBO_MASK_PWR_POL 8'h01

// ****************************************
// Reset values
// ****************************************
`define CBO_RST_STOP 8'h00
`define CBO_RST_PULL 8'h51
`define CBO_RST_PWR_PULL 8'h02
`define CBO_RST_EN_POL 8'h00
`define CBO_RST_PWR_POL 8'h00
`define CBO_IMP_DEFAULT 2'h2

`endif

// ---- design/cbo_pkg.sv ----
// Purpose: Types for the output config bank
// Assumes: cbo_defines.svh
// Notes: Codes follow the register encodings
package cbo_pkg;
    typedef enum logic [1:0] {
        CBO_STOP_LOW_LOW = 2'b00,
        CBO_STOP_HIZ = 2'b01,
        CBO_STOP_HIGH_LOW = 2'b10,
        CBO_STOP_LOW_HIGH = 2'b11
    } cbo_stop_t;

    typedef enum logic [1:0] {
        CBO_IMP_33 = 2'b00,
        CBO_IMP_85 = 2'b01,
        CBO_IMP_100 = 2'b10,
        CBO_IMP_RSVD = 2'b11
    } cbo_imp_t;

    typedef enum logic [1:0] {
        CBO_PULL_NONE = 2'b00,
        CBO_PULL_DOWN = 2'b01,
        CBO_PULL_UP = 2'b10,
        CBO_PULL_BOTH = 2'b11
    } cbo_pull_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } cbo_req_t;

    // Drive of one disabled pair
    typedef struct packed {
        logic true_oe;
        logic true_lvl;
        logic comp_oe;
        logic comp_lvl;
    } cbo_pair_t;
endpackage

// ---- design/cbo_config_bank.sv ----
// Purpose: Output configuration registers of a six-output clock generator
// Assumes: Byte access from the SMBus engine, one request per cycle
// Notes: Read data is registered, valid the cycle after the address
`timescale 1ns/1ps
`include "cbo_defines.svh"

module cbo_config_bank
    import cbo_pkg::*;
#(
    parameter int NUM_OUT = 6,
    parameter logic [1:0] IMP_DEFAULT = `CBO_IMP_DEFAULT
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire cbo_req_t i_req,
    output logic [7:0] o_rd_data,
    output logic o_addr_hit,
    // Pin levels
    input wire logic [NUM_OUT-1:0] i_enable_pin,
    input wire logic i_power_good_powerdown_pin,
    // Decoded settings
    output cbo_pair_t o_stopped_pair,
    output logic o_ref_stop_oe,
    output logic o_ref_stop_lvl,
    output logic [2*NUM_OUT-1:0] o_impedance_sel,
    output logic [2*NUM_OUT-1:0] o_enable_pull_sel,
    output logic [1:0] o_power_pin_pull_sel,
    output logic [NUM_OUT-1:0] o_output_enabled,
    output logic o_powerdown
);

    // ****************************************
    // Registers
    // ****************************************
    localparam logic [7:0] IMP_RST = {IMP_DEFAULT, IMP_DEFAULT, 2'b00, IMP_DEFAULT};

    logic [7:0] stop_state_control_reg;
    logic [7:0] output_impedance_low_reg;
    logic [7:0] output_impedance_high_reg;
    logic [7:0] enable_pin_pull_low_reg;
    logic [7:0] enable_pin_pull_high_reg;
    logic [7:0] power_pin_pull_reg;
    logic [7:0] enable_pin_polarity_reg;
    logic [7:0] power_pin_polarity_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // ****************************************
    // Address decode
    // ****************************************
    wire sel_stop = i_req.addr == `CBO_OFF_STOP;
    wire sel_imp_lo = i_req.addr == `CBO_OFF_IMP_LO;
    wire sel_imp_hi = i_req.addr == `CBO_OFF_IMP_HI;
    wire sel_pull_lo = i_req.addr == `CBO_OFF_PULL_LO;
    wire sel_pull_hi = i_req.addr == `CBO_OFF_PULL_HI;
    wire sel_pwr_pull = i_req.addr == `CBO_OFF_PWR_PULL;
    wire sel_en_pol = i_req.addr == `CBO_OFF_EN_POL;
    wire sel_pwr_pol = i_req.addr == `CBO_OFF_PWR_POL;
    wire [7:0] wd = i_req.data;

    assign o_addr_hit = sel_stop | sel_imp_lo | sel_imp_hi | sel_pull_lo | sel_pull_hi
        | sel_pwr_pull | sel_en_pol | sel_pwr_pol;

    // Unmapped and reserved addresses read zero
    assign rd_data_next =
        ({8{sel_stop}} & stop_state_control_reg)
        | ({8{sel_imp_lo}} & output_impedance_low_reg)
        | ({8{sel_imp_hi}} & output_impedance_high_reg)
        | ({8{sel_pull_lo}} & enable_pin_pull_low_reg)
        | ({8{sel_pull_hi}} & enable_pin_pull_high_reg)
        | ({8{sel_pwr_pull}} & power_pin_pull_reg)
        | ({8{sel_en_pol}} & enable_pin_polarity_reg)
        | ({8{sel_pwr_pol}} & power_pin_polarity_reg);

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            stop_state_control_reg <= `CBO_RST_STOP;
            output_impedance_low_reg <= IMP_RST;
            output_impedance_high_reg <= IMP_RST;
            enable_pin_pull_low_reg <= `CBO_RST_PULL;
            enable_pin_pull_high_reg <= `CBO_RST_PULL;
            power_pin_pull_reg <= `CBO_RST_PWR_PULL;
            enable_pin_polarity_reg <= `CBO_RST_EN_POL;
            power_pin_polarity_reg <= `CBO_RST_PWR_POL;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            if (i_req.wr && sel_stop)
                stop_state_control_reg <= wd & `CBO_MASK_STOP;
            if (i_req.wr && sel_imp_lo)
                output_impedance_low_reg <= wd & `CBO_MASK_TRIPLE;
            if (i_req.wr && sel_imp_hi)
                output_impedance_high_reg <= wd & `CBO_MASK_TRIPLE;
            if (i_req.wr && sel_pull_lo)
                enable_pin_pull_low_reg <= wd & `CBO_MASK_TRIPLE;
            if (i_req.wr && sel_pull_hi)
                enable_pin_pull_high_reg <= wd & `CBO_MASK_TRIPLE;
            if (i_req.wr && sel_pwr_pull)
                power_pin_pull_reg <= wd & `CBO_MASK_PWR_PULL;
            if (i_req.wr && sel_en_pol)
                enable_pin_polarity_reg <= wd & `CBO_MASK_EN_POL;
            if (i_req.wr && sel_pwr_pol)
                power_pin_polarity_reg <= wd & `CBO_MASK_PWR_POL;
        end
    end

    assign o_rd_data = rd_data_reg;

    // ****************************************
    // Field decode
    // ****************************************
    cbo_stop_t stopped_output_state;
    assign stopped_output_state = cbo_stop_t'(stop_state_control_reg[1:0]);

    wire [1:0] out0_impedance_sel = output_impedance_low_reg[1:0];
    wire [1:0] out1_impedance_sel = output_impedance_low_reg[5:4];
    wire [1:0] out2_impedance_sel = output_impedance_low_reg[7:6];
    wire [1:0] out3_impedance_sel = output_impedance_high_reg[1:0];
    wire [1:0] out4_impedance_sel = output_impedance_high_reg[5:4];
    wire [1:0] out5_impedance_sel = output_impedance_high_reg[7:6];
    assign o_impedance_sel = {out5_impedance_sel, out4_impedance_sel, out3_impedance_sel,
        out2_impedance_sel, out1_impedance_sel, out0_impedance_sel};

    wire [1:0] enable0_pull_sel = enable_pin_pull_low_reg[1:0];
    wire [1:0] enable1_pull_sel = enable_pin_pull_low_reg[5:4];
    wire [1:0] enable2_pull_sel = enable_pin_pull_low_reg[7:6];
    wire [1:0] enable3_pull_sel = enable_pin_pull_high_reg[1:0];
    wire [1:0] enable4_pull_sel = enable_pin_pull_high_reg[5:4];
    wire [1:0] enable5_pull_sel = enable_pin_pull_high_reg[7:6];
    assign o_enable_pull_sel = {enable5_pull_sel, enable4_pull_sel, enable3_pull_sel,
        enable2_pull_sel, enable1_pull_sel, enable0_pull_sel};
    assign o_power_pin_pull_sel = power_pin_pull_reg[1:0];

    wire [5:0] enable_active_level = {enable_pin_polarity_reg[7:6],
        enable_pin_polarity_reg[4:2], enable_pin_polarity_reg[0]};

    // Pin high matches active level when polarity is 1
    assign o_output_enabled = ~(i_enable_pin[5:0] ^ enable_active_level);
    assign o_powerdown = ~(i_power_good_powerdown_pin ^ power_pin_polarity_reg[0]);

    // ****************************************
    // Stopped state drive
    // ****************************************
    always_comb
    begin
        o_stopped_pair = '{true_oe: 1'b1, true_lvl: 1'b0, comp_oe: 1'b1, comp_lvl: 1'b0};
        o_ref_stop_oe = 1'b1;
        o_ref_stop_lvl = 1'b0;
        unique case (stopped_output_state)
            CBO_STOP_LOW_LOW:
            begin
                o_stopped_pair = '{1'b1, 1'b0, 1'b1, 1'b0};
                o_ref_stop_lvl = 1'b0;
            end
            CBO_STOP_HIZ:
            begin
                o_stopped_pair = '{1'b0, 1'b0, 1'b0, 1'b0};
                o_ref_stop_oe = 1'b0;
            end
            CBO_STOP_HIGH_LOW:
            begin
                o_stopped_pair = '{1'b1, 1'b1, 1'b1, 1'b0};
                o_ref_stop_lvl = 1'b0;
            end
            CBO_STOP_LOW_HIGH:
            begin
                o_stopped_pair = '{1'b1, 1'b0, 1'b1, 1'b1};
                o_ref_stop_lvl = 1'b1;
            end
        endcase
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_write_to(logic [7:0] off);
        i_req.wr && i_req.addr == off;
    endsequence

    sequence s_read_of(logic [7:0] off);
        !i_req.wr && i_req.addr == off;
    endsequence

    // Write, then the same register read next cycle
    sequence s_write_read(logic [7:0] off);
        s_write_to(off) ##1 s_read_of(off);
    endsequence

    a_stop_write_mask: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_STOP) |=> stop_state_control_reg == ($past(wd) & 8'h03))
        else $error("stop state write wrong");
    a_hiz_both_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stop_state_control_reg[1:0] == 2'b01 |-> !o_stopped_pair.true_oe
        && !o_stopped_pair.comp_oe && !o_ref_stop_oe)
        else $error("hiz stop state drives");
    a_imp_field_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_IMP_HI) |=> o_impedance_sel[11:10] == $past(wd[7:6])
        && o_impedance_sel[7:6] == $past(wd[1:0]))
        else $error("impedance field map wrong");
    a_imp_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        output_impedance_low_reg[3:2] == 2'b00 && output_impedance_high_reg[3:2] == 2'b00)
        else $error("impedance reserved bits set");
    a_pull_field_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PULL_LO) |=> o_enable_pull_sel[5:4] == $past(wd[7:6]))
        else $error("pull field map wrong");
    a_pull_reset_down: assert property (@(posedge i_ref_clk)
        $past(i_rst) && i_rst == 1'b0 |-> o_enable_pull_sel == 12'h555
        && o_power_pin_pull_sel == 2'b10)
        else $error("pull reset value wrong");
    a_pwr_pull_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !(i_req.wr && i_req.addr == `CBO_OFF_PWR_PULL) |=> $stable(o_power_pin_pull_sel))
        else $error("power pull changed without write");
    a_enable_polarity: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        enable_pin_polarity_reg[7] |-> o_output_enabled[5] == i_enable_pin[5])
        else $error("enable polarity wrong");
    a_powerdown_pol: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !power_pin_polarity_reg[0] |-> o_powerdown == !i_power_good_powerdown_pin)
        else $error("powerdown polarity wrong");
    a_rsvd_read_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_req.addr == 8'h11 |=> o_rd_data == 8'h00)
        else $error("reserved register reads nonzero");
    a_imp_lo_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_IMP_LO) |=> output_impedance_low_reg == ($past(wd) & 8'hf3))
        else $error("impedance low write wrong");
    a_imp_hi_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_IMP_HI) |=> output_impedance_high_reg == ($past(wd) & 8'hf3))
        else $error("impedance high write wrong");
    a_pull_lo_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PULL_LO) |=> enable_pin_pull_low_reg == ($past(wd) & 8'hf3))
        else $error("pull low write wrong");
    a_pull_hi_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PULL_HI) |=> enable_pin_pull_high_reg == ($past(wd) & 8'hf3))
        else $error("pull high write wrong");
    a_pwr_pull_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PWR_PULL) |=> o_power_pin_pull_sel == $past(wd[1:0]))
        else $error("power pull write wrong");
    a_en_pol_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_EN_POL) |=> enable_pin_polarity_reg == ($past(wd) & 8'hdd))
        else $error("enable polarity write wrong");
    a_pwr_pol_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PWR_POL) |=> power_pin_polarity_reg == ($past(wd) & 8'h01))
        else $error("power polarity write wrong");
    a_imp_lo_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_IMP_LO) |=> o_impedance_sel[5:0] == {$past(wd[7:6]),
        $past(wd[5:4]), $past(wd[1:0])})
        else $error("impedance low map wrong");
    a_pull_hi_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(`CBO_OFF_PULL_HI) |=> o_enable_pull_sel[11:6] == {$past(wd[7:6]),
        $past(wd[5:4]), $past(wd[1:0])})
        else $error("pull high map wrong");
    a_stop_low_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stop_state_control_reg[1:0] == 2'b00 |-> o_stopped_pair == 4'ha)
        else $error("low low stop drive wrong");
    a_stop_high_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stop_state_control_reg[1:0] == 2'b10 |-> o_stopped_pair == 4'he)
        else $error("high low stop drive wrong");
    a_stop_low_high: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stop_state_control_reg[1:0] == 2'b11 |-> o_stopped_pair == 4'hb)
        else $error("low high stop drive wrong");
    a_ref_stop_level: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stop_state_control_reg[1:0] != 2'b01 |-> o_ref_stop_oe
        && (o_ref_stop_lvl == (stop_state_control_reg[1:0] == 2'b11)))
        else $error("reference stop level wrong");
    a_rsvd_reg_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_to(8'h11) |=> $stable(power_pin_pull_reg) && $stable(enable_pin_polarity_reg))
        else $error("reserved register write landed");
    a_addr_hit_rsvd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_req.addr == 8'h11 |-> !o_addr_hit)
        else $error("reserved register decoded");
    a_reg_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_req.wr |=> $stable(stop_state_control_reg) && $stable(output_impedance_low_reg)
        && $stable(output_impedance_high_reg) && $stable(enable_pin_pull_low_reg)
        && $stable(enable_pin_pull_high_reg) && $stable(enable_pin_polarity_reg)
        && $stable(power_pin_polarity_reg))
        else $error("register changed without write");
    a_stop_readback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_read(`CBO_OFF_STOP) |=> o_rd_data == ($past(wd, 2) & 8'h03))
        else $error("stop state readback wrong");
    a_pol_readback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_read(`CBO_OFF_EN_POL) |=> o_rd_data == ($past(wd, 2) & 8'hdd))
        else $error("enable polarity readback wrong");
    a_enable_pol_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !enable_pin_polarity_reg[0] |-> o_output_enabled[0] == !i_enable_pin[0])
        else $error("active low enable wrong");
    a_powerdown_high: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        power_pin_polarity_reg[0] |-> o_powerdown == i_power_good_powerdown_pin)
        else $error("active high powerdown wrong");
    a_reset_defaults: assert property (@(posedge i_ref_clk)
        $past(i_rst) && i_rst == 1'b0 |-> stop_state_control_reg == 8'h00
        && output_impedance_low_reg == IMP_RST && output_impedance_high_reg == IMP_RST
        && enable_pin_polarity_reg == 8'h00 && power_pin_polarity_reg == 8'h00)
        else $error("register reset value wrong");

endmodule // cbo_config_bank

// ---- tb/cbo_host_model.sv ----
// Purpose: Register host that drives the config bank request port
// Assumes: Requests launched on the rising edge, one per cycle
// Notes: Read data is taken one edge after the address
`timescale 1ns/1ps

module cbo_host_model
    import cbo_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Register port
    output cbo_req_t o_req,
    input wire logic [7:0] i_rd_data
);
    initial o_req = '0;

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        o_req <= '{wr: 1'b1, addr: addr, data: data};
    endtask

    task automatic idle();
        @(posedge i_ref_clk);
        o_req <= '{wr: 1'b0, addr: o_req.addr, data: 8'h00};
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_ref_clk);
        o_req <= '{wr: 1'b0, addr: addr, data: 8'h00};
        @(posedge i_ref_clk);
        #1;
        data = i_rd_data;
    endtask
endmodule // cbo_host_model

// ---- tb/test_cbo_config_bank.sv ----
// Purpose: Self-checking bench for the output config bank
// Assumes: Host model drives the register port
// Notes: Pins are driven by the bench
`timescale 1ns/1ps

module test_cbo_config_bank
    import cbo_pkg::*;
;
    localparam logic [1:0] IMP = 2'h2;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    cbo_req_t req;
    logic [7:0] rd_data;
    logic addr_hit;
    logic [5:0] enable_pin = 6'h00;
    logic power_pin = 1'b0;
    cbo_pair_t stopped_pair;
    logic ref_oe;
    logic ref_lvl;
    logic [11:0] imp_sel;
    logic [11:0] pull_sel;
    logic [1:0] pwr_pull;
    logic [5:0] out_en;
    logic powerdown;
    int err_count = 0;
    int compares = 0;

    always #10 ref_clk = ~ref_clk;

    cbo_host_model u_host (.i_ref_clk(ref_clk), .o_req(req), .i_rd_data(rd_data));

    cbo_config_bank #(.NUM_OUT(6), .IMP_DEFAULT(IMP)) u_dut (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_req(req), .o_rd_data(rd_data),
        .o_addr_hit(addr_hit), .i_enable_pin(enable_pin),
        .i_power_good_powerdown_pin(power_pin), .o_stopped_pair(stopped_pair),
        .o_ref_stop_oe(ref_oe), .o_ref_stop_lvl(ref_lvl), .o_impedance_sel(imp_sel),
        .o_enable_pull_sel(pull_sel), .o_power_pin_pull_sel(pwr_pull),
        .o_output_enabled(out_en), .o_powerdown(powerdown));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        check(12'(d), 12'(exp));
    endtask

    task automatic set_pins(input logic [5:0] p, input logic pw);
        @(posedge ref_clk);
        enable_pin <= p;
        power_pin <= pw;
        #1;
    endtask

    task automatic complete_run();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        logic [7:0] exp [10] = '{8'h00, 8'h00, {IMP, IMP, 2'b00, IMP}, {IMP, IMP, 2'b00, IMP},
            8'h51, 8'h51, 8'h02, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++)
        begin
            rd_check(8'h0a + 8'(i), exp[i]);
            check(12'(addr_hit), (i == 0 || i == 7) ? 12'h0 : 12'h1);
        end
        check(imp_sel, {6{IMP}});
        check(pull_sel, 12'h555);
        check(12'(pwr_pull), 12'h2);
    endtask

    task automatic test_stop();
        logic [3:0] pair_exp [4] = '{4'ha, 4'h0, 4'he, 4'hb};
        logic [1:0] ref_exp [4] = '{2'b10, 2'b00, 2'b10, 2'b11};
        for (int c = 0; c < 4; c++)
        begin
            u_host.write_reg(8'h0b, {6'h3f, 2'(c)});
            u_host.idle();
            #1;
            check(12'(stopped_pair), 12'(pair_exp[c]));
            check(12'({ref_oe, ref_lvl & ref_oe}), 12'(ref_exp[c]));
            rd_check(8'h0b, 8'(c));
        end
    endtask

    task automatic test_imp_pull();
        u_host.write_reg(8'h0c, 8'h1f);
        u_host.write_reg(8'h0d, 8'he6);
        u_host.write_reg(8'h0e, 8'h6c);
        u_host.write_reg(8'h0f, 8'hb7);
        u_host.write_reg(8'h10, 8'hff);
        u_host.idle();
        #1;
        check(imp_sel, 12'he87);
        check(pull_sel, 12'hbd8);
        check(12'(pwr_pull), 12'h3);
        rd_check(8'h0c, 8'h13);
        rd_check(8'h0d, 8'he2);
        rd_check(8'h0e, 8'h60);
        rd_check(8'h0f, 8'hb3);
        rd_check(8'h10, 8'h03);
    endtask

    task automatic test_polarity();
        u_host.write_reg(8'h12, 8'h14);
        u_host.idle();
        set_pins(6'b001010, 1'b0);
        check(12'(out_en), 12'h3f);
        check(12'(powerdown), 12'h1);
        set_pins(6'b110101, 1'b1);
        check(12'(out_en), 12'h00);
        check(12'(powerdown), 12'h0);
        u_host.write_reg(8'h12, 8'hff);
        u_host.write_reg(8'h13, 8'hff);
        u_host.idle();
        #1;
        check(12'(out_en), 12'h35);
        check(12'(powerdown), 12'h1);
        rd_check(8'h12, 8'hdd);
        rd_check(8'h13, 8'h01);
    endtask

    task automatic test_unmapped();
        u_host.write_reg(8'h11, 8'hff);
        u_host.write_reg(8'h0a, 8'h00);
        u_host.write_reg(8'h11, 8'h00);
        u_host.idle();
        rd_check(8'h11, 8'h00);
        check(12'(addr_hit), 12'h0);
        rd_check(8'h0b, 8'h03);
        rd_check(8'h10, 8'h03);
        rd_check(8'h12, 8'hdd);
    endtask

    task automatic test_reset_again();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset();
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset();
        test_stop();
        test_imp_pull();
        test_polarity();
        test_unmapped();
        test_reset_again();
        complete_run();
    end

    initial
    begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule // test_cbo_config_bank
